// >>> core/wpsc_defines.svh
// register offsets, field positions, reset values and limits of the pattern source block
`ifndef WPSC_DEFINES_SVH
`define WPSC_DEFINES_SVH
`define WPSC_ADDR_SOURCE_SELECT   8'h45
`define WPSC_ADDR_TUNING_SHIFT    8'h47
`define WPSC_ADDR_INITIAL_WAIT    8'h5c
`define WPSC_ADDR_BEGIN_LOCATION  8'h5d
`define WPSC_ADDR_END_LOCATION    8'h5e
`define WPSC_ADDR_SINE_CYCLES     8'h5f
`define WPSC_ADDR_CONFIG_ERRORS   8'h60
`define WPSC_RST_ZERO             16'h0000
`define WPSC_RST_SINE_CYCLES      16'h0001
`define WPSC_BIT_COSINE           3
`define WPSC_BIT_ADDR_CLK_MSB     2
`define WPSC_BIT_PHASE_MEM        1
`define WPSC_BIT_TUNING_MEM       0
`define WPSC_SHIFT_MSB            4
`define WPSC_SHIFT_FULL_WORD      5'h0a
`define WPSC_SHIFT_MAX            5'h10
`define WPSC_ADDR_FIELD_MSB       15
`define WPSC_ADDR_FIELD_LSB       4
`define WPSC_ERR_CLEAR_BIT        15
`define WPSC_ERR_MARKER_LARGE     5
`define WPSC_ERR_PAT_DLY_SHORT    4
`define WPSC_ERR_MARKER_SHORT     3
`define WPSC_ERR_PERIOD_SHORT     2
`define WPSC_ERR_ODD_LENGTH       1
`define WPSC_ERR_MEM_CONFLICT     0
`define WPSC_ERR_FLAG_MASK        16'h003f
`endif

// >>> core/wpsc_pkg.sv
// types shared by the pattern source configuration block
`default_nettype none
package wpsc_pkg;
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [7:0]  addr;
      logic [15:0] wdata;
   } wpsc_access_type;

   typedef struct packed {
      logic        marker_delay_too_large;
      logic        pattern_delay_short;
      logic        marker_delay_short;
      logic        period_short;
      logic        odd_length;
      logic        memory_conflict;
   } wpsc_error_events_type;

   typedef struct packed {
      logic        cosine_select;
      logic        address_clock_from_phase_msb;
      logic [23:0] tuning_word;
      logic [15:0] phase_offset;
      logic [11:0] begin_address;
      logic [11:0] end_address;
      logic [15:0] initial_wait;
      logic [15:0] sine_cycle_count;
   } wpsc_dds_setup_type;

   typedef enum logic [1:0] {
      WPSC_IDLE  = 2'b00,
      WPSC_WAIT  = 2'b01,
      WPSC_PLAY  = 2'b10
   } wpsc_seq_type;
endpackage
`default_nettype wire

// >>> core/wpsc_config.sv
// pattern source configuration registers, tuning word merge, start delay sequencing
//
// Notes on behaviour
// R1 - cosine select set gives cosine output; clear gives sine.
// R2 - address counter clock from dac clock at 0, phase msb at 1.
// R3 - phase offset from memory data at 1, from phase offset register at 0.
// R4 - tuning word from memory merge at 1, from tuning word registers at 0.
// R5 - shift zero: memory word in top bits, ten zeros below.
// R6 - shift 1..10: top n register bits, memory word, 10-n zeros.
// R7 - shift 11..16: top n register bits, upper 24-n memory bits; above reserved.
// R8 - playback start address from bits 15..4 of begin register.
// R9 - playback stop address from bits 15..4 of end register.
// R10 - sine cycle count register, 16 bits, resets to one.
// R11 - writing bit 15 of error register clears all error flags.
// R12 - bit 5 set when marker delay exceeds pattern delay.
// R13 - bit 4 set when pattern delay below its default.
// R14 - bit 3 set when marker start delay below its default.
// R15 - bit 2 set when pattern period shorter than playback duration.
// R16 - bit 1 set when trigger-delay pattern has odd length.
// R17 - bit 0 set on conflicting pattern memory access during reading.
// R18 - each start delay step lasts wait unit clocks, zero meaning one.
// R19 - first-pattern-only set: delay before first pattern; clear: before each.
// R20 - error flags sticky until clear bit written; other bits ignore writes.
`include "wpsc_defines.svh"
`default_nettype none
module wpsc_config (
   // clock and reset
   input  wire logic                      mclk,
   input  wire logic                      reset,
   // configuration port
   input  wire wpsc_pkg::wpsc_access_type access,
   output var  logic [15:0]               rdata,
   // settings held elsewhere in the device
   input  wire logic [15:0]               tuning_word_regs,
   input  wire logic [7:0]                tuning_word_low,
   input  wire logic [15:0]               phase_offset_reg,
   input  wire logic [3:0]                wait_unit_clocks,
   input  wire logic                      delay_first_pattern_only,
   // pattern controller
   input  wire logic [13:0]               memory_data,
   input  wire logic                      pattern_request,
   input  wire logic                      pattern_done,
   input  wire logic                      playback_reset,
   input  wire wpsc_pkg::wpsc_error_events_type error_events,
   // synthesizer controls
   output var  wpsc_pkg::wpsc_dds_setup_type   dds_setup,
   output var  logic                      play_enable,
   output var  logic                      waiting
);
   import wpsc_pkg::*;

   logic [15:0] source_select_reg, source_select_next;
   logic [15:0] tuning_shift_reg, tuning_shift_next;
   logic [15:0] initial_wait_reg, initial_wait_next;
   logic [15:0] begin_location_reg, begin_location_next;
   logic [15:0] end_location_reg, end_location_next;
   logic [15:0] sine_cycles_reg, sine_cycles_next;
   logic [5:0]  error_flags_reg, error_flags_next;
   logic [15:0] rdata_next;
   wpsc_dds_setup_type dds_setup_next;

   wpsc_seq_type seq_reg, seq_next;
   logic [15:0]  steps_reg, steps_next;
   logic [3:0]   unit_reg, unit_next;
   logic         first_done_reg, first_done_next;

   // merge of memory word into the 24-bit tuning word
   function automatic logic [23:0] merge_tuning(input logic [23:0] regs,
                                                input logic [13:0] mem,
                                                input logic [4:0]  shift);
      logic [23:0] keep_mask;
      logic [23:0] mem_placed;
      keep_mask  = 24'h000000;
      mem_placed = 24'h000000;
      if (shift <= `WPSC_SHIFT_FULL_WORD) begin
         mem_placed = {mem, 10'h000} >> shift;          // [R5] [R6]
      end else begin
         mem_placed = {10'h000, mem} >> (shift - `WPSC_SHIFT_FULL_WORD); // [R7]
      end
      if (shift <= `WPSC_SHIFT_MAX) begin
         keep_mask = ~(24'hffffff >> shift);
      end else begin
         // reserved: register word only
         mem_placed = 24'h000000;
         keep_mask  = 24'hffffff;
      end
      return (regs & keep_mask) | (mem_placed & ~keep_mask);
   endfunction

   function automatic logic [11:0] addr_field(input logic [15:0] r);
      return r[`WPSC_ADDR_FIELD_MSB:`WPSC_ADDR_FIELD_LSB];
   endfunction

   // register writes and readback
   always_comb begin
      logic wr;
      wr = access.valid && access.write;
      source_select_next  = source_select_reg;
      tuning_shift_next   = tuning_shift_reg;
      initial_wait_next   = initial_wait_reg;
      begin_location_next = begin_location_reg;
      end_location_next   = end_location_reg;
      sine_cycles_next    = sine_cycles_reg;
      error_flags_next    = error_flags_reg;
      if (wr) begin
         unique case (access.addr)
            `WPSC_ADDR_SOURCE_SELECT:  source_select_next  = access.wdata;
            `WPSC_ADDR_TUNING_SHIFT:   tuning_shift_next   = access.wdata;
            `WPSC_ADDR_INITIAL_WAIT:   initial_wait_next   = access.wdata;
            `WPSC_ADDR_BEGIN_LOCATION: begin_location_next = access.wdata;
            `WPSC_ADDR_END_LOCATION:   end_location_next   = access.wdata;
            `WPSC_ADDR_SINE_CYCLES:    sine_cycles_next    = access.wdata; // [R10]
            `WPSC_ADDR_CONFIG_ERRORS: begin
               if (access.wdata[`WPSC_ERR_CLEAR_BIT]) begin
                  error_flags_next = 6'h00;                // [R11] [R20]
               end
            end
            default: ;
         endcase
      end
      // set wins over a clear in the same cycle
      error_flags_next = error_flags_next | error_events; // [R12] [R13] [R14] [R15] [R16] [R17] [R20]
      rdata_next = rdata;
      if (access.valid && !access.write) begin
         unique case (access.addr)
            `WPSC_ADDR_SOURCE_SELECT:  rdata_next = source_select_reg;
            `WPSC_ADDR_TUNING_SHIFT:   rdata_next = tuning_shift_reg;
            `WPSC_ADDR_INITIAL_WAIT:   rdata_next = initial_wait_reg;
            `WPSC_ADDR_BEGIN_LOCATION: rdata_next = begin_location_reg;
            `WPSC_ADDR_END_LOCATION:   rdata_next = end_location_reg;
            `WPSC_ADDR_SINE_CYCLES:    rdata_next = sine_cycles_reg;
            `WPSC_ADDR_CONFIG_ERRORS:  rdata_next = {10'h000, error_flags_reg};
            default:                   rdata_next = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         source_select_reg  <= `WPSC_RST_ZERO;
         tuning_shift_reg   <= `WPSC_RST_ZERO;
         initial_wait_reg   <= `WPSC_RST_ZERO;
         begin_location_reg <= `WPSC_RST_ZERO;
         end_location_reg   <= `WPSC_RST_ZERO;
         sine_cycles_reg    <= `WPSC_RST_SINE_CYCLES;     // [R10]
         error_flags_reg    <= 6'h00;
         rdata              <= 16'h0000;
      end else begin
         source_select_reg  <= source_select_next;
         tuning_shift_reg   <= tuning_shift_next;
         initial_wait_reg   <= initial_wait_next;
         begin_location_reg <= begin_location_next;
         end_location_reg   <= end_location_next;
         sine_cycles_reg    <= sine_cycles_next;
         error_flags_reg    <= error_flags_next;
         rdata              <= rdata_next;
      end
   end

   // synthesizer source selection
   always_comb begin
      logic [23:0] reg_word;
      reg_word = {tuning_word_regs, tuning_word_low};
      dds_setup_next.cosine_select = source_select_reg[`WPSC_BIT_COSINE];      // [R1]
      dds_setup_next.address_clock_from_phase_msb =
         source_select_reg[`WPSC_BIT_ADDR_CLK_MSB];                           // [R2]
      dds_setup_next.phase_offset = source_select_reg[`WPSC_BIT_PHASE_MEM] ?
         {memory_data, 2'b00} : phase_offset_reg;                             // [R3]
      dds_setup_next.tuning_word = source_select_reg[`WPSC_BIT_TUNING_MEM] ?
         merge_tuning(reg_word, memory_data,
                      tuning_shift_reg[`WPSC_SHIFT_MSB:0]) : reg_word;        // [R4]
      dds_setup_next.begin_address = addr_field(begin_location_reg);          // [R8]
      dds_setup_next.end_address   = addr_field(end_location_reg);            // [R9]
      dds_setup_next.initial_wait  = initial_wait_reg;
      dds_setup_next.sine_cycle_count = sine_cycles_reg;                      // [R10]
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         dds_setup <= '0;
      end else begin
         dds_setup <= dds_setup_next;
      end
   end

   // start delay sequencer
   always_comb begin
      seq_next        = seq_reg;
      steps_next      = steps_reg;
      unit_next       = unit_reg;
      first_done_next = first_done_reg;
      unique case (seq_reg)
         WPSC_IDLE: begin
            if (pattern_request) begin
               if (delay_first_pattern_only && first_done_reg) begin
                  seq_next = WPSC_PLAY;                   // [R19]
               end else begin
                  seq_next   = WPSC_WAIT;
                  steps_next = initial_wait_reg;
                  unit_next  = wait_unit_clocks;
               end
            end
         end
         WPSC_WAIT: begin
            if (steps_reg == 16'h0000) begin
               seq_next        = WPSC_PLAY;
               first_done_next = 1'b1;
            end else if (unit_reg <= 4'h1) begin
               unit_next  = wait_unit_clocks;             // [R18]
               steps_next = steps_reg - 16'h0001;
            end else begin
               unit_next = unit_reg - 4'h1;               // [R18]
            end
         end
         WPSC_PLAY: begin
            if (pattern_done) begin
               seq_next = WPSC_IDLE;
            end
         end
         default: seq_next = WPSC_IDLE;
      endcase
      if (playback_reset) begin
         seq_next        = WPSC_IDLE;
         first_done_next = 1'b0;
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         seq_reg        <= WPSC_IDLE;
         steps_reg      <= 16'h0000;
         unit_reg       <= 4'h0;
         first_done_reg <= 1'b0;
      end else begin
         seq_reg        <= seq_next;
         steps_reg      <= steps_next;
         unit_reg       <= unit_next;
         first_done_reg <= first_done_next;
      end
   end

   assign play_enable = (seq_reg == WPSC_PLAY);
   assign waiting     = (seq_reg == WPSC_WAIT);
endmodule // wpsc_config
`default_nettype wire

// >>> bench/wpsc_config_asserts.sv
// assertion checker for the pattern source configuration block
`default_nettype none
module wpsc_config_asserts (
   // clock and reset
   input wire logic                        mclk,
   input wire logic                        reset,
   // observed ports
   input wire wpsc_pkg::wpsc_access_type   access,
   input wire logic [15:0]                 rdata,
   input wire logic [15:0]                 tuning_word_regs,
   input wire logic [7:0]                  tuning_word_low,
   input wire logic [15:0]                 phase_offset_reg,
   input wire wpsc_pkg::wpsc_dds_setup_type dds_setup
);
   timeunit 1ns;
   timeprecision 1ps;
   import wpsc_pkg::*;
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   // write to one place, not overwritten in the next cycle
   sequence s_wr(logic [7:0] a);
      access.valid && access.write && access.addr == a
      ##1 !(access.valid && access.write && access.addr == a);
   endsequence
   property p_cos;
      s_wr(8'h45) |=> dds_setup.cosine_select == $past(access.wdata[3], 2);
   endproperty
   a_cos: assert property (p_cos) else $error("cosine select mismatch");
   property p_msb;
      s_wr(8'h45) |=> dds_setup.address_clock_from_phase_msb == $past(access.wdata[2], 2);
   endproperty
   a_msb: assert property (p_msb) else $error("address clock select mismatch");
   property p_phase;
      !access.wdata[1] ##0 s_wr(8'h45) |=> dds_setup.phase_offset == $past(phase_offset_reg);
   endproperty
   a_phase: assert property (p_phase) else $error("phase offset source mismatch");
   property p_tw;
      !access.wdata[0] ##0 s_wr(8'h45)
         |=> dds_setup.tuning_word == $past({tuning_word_regs, tuning_word_low});
   endproperty
   a_tw: assert property (p_tw) else $error("tuning word source mismatch");
   property p_begin;
      s_wr(8'h5d) |=> dds_setup.begin_address == $past(access.wdata[15:4], 2);
   endproperty
   a_begin: assert property (p_begin) else $error("begin address mismatch");
   property p_end;
      s_wr(8'h5e) |=> dds_setup.end_address == $past(access.wdata[15:4], 2);
   endproperty
   a_end: assert property (p_end) else $error("end address mismatch");
   property p_sine;
      s_wr(8'h5f) |=> dds_setup.sine_cycle_count == $past(access.wdata, 2);
   endproperty
   a_sine: assert property (p_sine) else $error("sine cycle count mismatch");
   property p_errhi;
      access.valid && !access.write && access.addr == 8'h60 |=> rdata[15:6] == 10'h000;
   endproperty
   a_errhi: assert property (p_errhi) else $error("error register upper bits set");
endmodule // wpsc_config_asserts
bind wpsc_config wpsc_config_asserts chk (.mclk(mclk), .reset(reset), .access(access),
   .rdata(rdata), .tuning_word_regs(tuning_word_regs), .tuning_word_low(tuning_word_low),
   .phase_offset_reg(phase_offset_reg), .dds_setup(dds_setup));
`default_nettype wire

// >>> bench/waveform_pattern_source_config_bench.sv
// self-checking bench for the pattern source configuration block
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module waveform_pattern_source_config_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import wpsc_pkg::*;
   logic mclk = 1'b0, reset = 1'b1, dfo = 1'b0, preq = 1'b0, pdone = 1'b0, prst = 1'b0;
   logic play, wt;
   logic [15:0] rdata, twr = 16'hb37d, por = 16'h1e4f;
   logic [7:0]  twl = 8'he9;
   logic [3:0]  wuc = 4'h0;
   logic [13:0] mem = 14'h2c5a;
   wpsc_access_type acc = '0;
   wpsc_error_events_type ev = '0;
   wpsc_dds_setup_type ds;
   int mismatches = 0, total_checks = 0;
   logic [7:0] adr [7] = '{8'h45, 8'h47, 8'h5c, 8'h5d, 8'h5e, 8'h5f, 8'h60};
   always #2 mclk = ~mclk;
   wpsc_config uut (.mclk(mclk), .reset(reset), .access(acc), .rdata(rdata),
      .tuning_word_regs(twr), .tuning_word_low(twl), .phase_offset_reg(por),
      .wait_unit_clocks(wuc), .delay_first_pattern_only(dfo), .memory_data(mem),
      .pattern_request(preq), .pattern_done(pdone), .playback_reset(prst),
      .error_events(ev), .dds_setup(ds), .play_enable(play), .waiting(wt));
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge mclk) acc <= '{1'b1, 1'b1, a, d};
      @(posedge mclk) acc.valid <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge mclk) acc <= '{1'b1, 1'b0, a, 16'h0000};
      @(posedge mclk) acc.valid <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic settle;
      repeat (3) @(posedge mclk);
      #1;
   endtask
   task automatic t_reset;
      logic [15:0] d;
      for (int i = 0; i < 7; i++) begin
         rd(adr[i], d);
         `CHK(d, (i == 5) ? 16'h0001 : 16'h0000)
      end
   endtask
   task automatic t_rw;
      logic [15:0] d;
      for (int i = 0; i < 6; i++) wr(adr[i], 16'ha5c3 ^ 16'(i));
      for (int i = 0; i < 6; i++) begin
         rd(adr[i], d);
         `CHK(d, 16'ha5c3 ^ 16'(i))
      end
      `CHK(ds.begin_address, 12'ha5c)
      `CHK(ds.end_address, 12'ha5c)
      `CHK(ds.sine_cycle_count, 16'ha5c6)
      rd(8'h46, d);
      `CHK(d, 16'h0000)
      wr(8'h60, 16'h7fff);
      rd(8'h60, d);
      `CHK(d, 16'h0000)
   endtask
   task automatic t_sel;
      logic [23:0] tw, m, e;
      tw = {twr, twl};
      wr(8'h45, 16'h0008);
      settle();
      `CHK({ds.cosine_select, ds.address_clock_from_phase_msb}, 2'b10)
      `CHK(ds.phase_offset, por)
      `CHK(ds.tuning_word, tw)
      wr(8'h45, 16'h0007);
      for (int n = 0; n < 18; n++) begin
         wr(8'h47, 16'(n));
         settle();
         m = 24'hffffff >> n;
         e = (tw & ~m) | ((n <= 10) ? (24'(mem) << (10 - n)) : (24'(mem) >> (n - 10)));
         `CHK(ds.tuning_word, (n > 16) ? tw : e)
      end
      `CHK({ds.cosine_select, ds.address_clock_from_phase_msb}, 2'b01)
      `CHK(ds.phase_offset, {mem, 2'b00})
   endtask
   task automatic t_err;
      logic [15:0] d, e;
      e = 16'h0000;
      for (int i = 0; i < 6; i++) begin
         @(posedge mclk) ev <= wpsc_error_events_type'(6'h01 << i);
         @(posedge mclk) ev <= '0;
         e = e | (16'h0001 << i);
         rd(8'h60, d);
         `CHK(d, e)
      end
      wr(8'h60, 16'h8000);
      rd(8'h60, d);
      `CHK(d, 16'h0000)
      // event and clear in one cycle: the event survives
      @(posedge mclk) begin
         acc <= '{1'b1, 1'b1, 8'h60, 16'h8000};
         ev  <= wpsc_error_events_type'(6'h01);
      end
      @(posedge mclk) begin
         acc.valid <= 1'b0;
         ev        <= '0;
      end
      rd(8'h60, d);
      `CHK(d, 16'h0001)
   endtask
   // one pattern: request, count cycles to play, then end it
   task automatic play_one(output int c);
      @(posedge mclk) preq <= 1'b1;
      @(posedge mclk) preq <= 1'b0;
      c = 0;
      #1;
      while (play !== 1'b1 && c < 60) begin
         `CHK(wt, 1'b1)
         @(posedge mclk);
         #1 c++;
      end
      @(posedge mclk) pdone <= 1'b1;
      @(posedge mclk) pdone <= 1'b0;
      #1 `CHK(play, 1'b0)
      `CHK(wt, 1'b0)
   endtask
   task automatic t_seq;
      int c;
      wr(8'h5c, 16'h0002);
      @(posedge mclk) wuc <= 4'h3;
      dfo <= 1'b1;
      play_one(c);
      `CHK(c >= 6 && c <= 9, 1'b1)
      play_one(c);
      `CHK(c == 0, 1'b1)
      @(posedge mclk) prst <= 1'b1;
      @(posedge mclk) prst <= 1'b0;
      play_one(c);
      `CHK(c >= 6 && c <= 9, 1'b1)
      @(posedge mclk) dfo <= 1'b0;
      play_one(c);
      play_one(c);
      `CHK(c >= 6 && c <= 9, 1'b1)
      // unit setting zero acts as one clock per step
      @(posedge mclk) wuc <= 4'h0;
      play_one(c);
      `CHK(c >= 2 && c <= 4, 1'b1)
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge mclk);
      reset <= 1'b0;
      t_reset();
      t_rw();
      t_sel();
      t_err();
      t_seq();
      final_report();
   end
   initial begin
      repeat (20000) @(posedge mclk);
      mismatches++;
      final_report();
   end
endmodule // waveform_pattern_source_config_bench
`default_nettype wire
